// [resistor_frequency_converter_ctl_tb.sv]
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero-wait APB slave, short gate length
// Notes: Prints only mismatches and the verdict
`timescale 1ns/1ps
`include "rfc_consts.svh"

module resistor_frequency_converter_ctl_tb;
  localparam int GATE = 16;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [18:0] gpio_out = 19'h5_a5a5;
  logic [18:0] gpio_oe = 19'h0_0000;
  logic [18:0] net_out;
  logic [18:0] net_oe;
  logic gpio_cap_out = 1'h1;
  logic gpio_cap_oe = 1'h1;
  logic cap_in;
  logic cap_out;
  logic cap_oe;
  logic irq_req;
  logic [11:0] irq_vec;
  logic [31:0] rdv;
  logic errv;
  int mismatches = 0;
  int tests_run = 0;
  int irq_cnt = 0;

  rfc_ctl #(.GATE_CYCLES(GATE), .NUM_CHAN(19)) u_rfc_ctl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .network_output_pin_out(net_out), .network_output_pin_oe(net_oe),
    .gpio_cap_out(gpio_cap_out), .gpio_cap_oe(gpio_cap_oe),
    .capacitor_pin_in(cap_in), .capacitor_pin_out(cap_out),
    .capacitor_pin_oe(cap_oe), .irq_vector_req(irq_req),
    .irq_vector(irq_vec)
  );

  rfc_net_model u_rfc_net_model (
    .net_oe(net_oe), .cap_oe(cap_oe), .cap_in(cap_in)
  );

  always #25 pclk = ~pclk;

  always @(posedge pclk) begin
    if (irq_req === 1'h1) begin
      irq_cnt++;
    end
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer; starts and ends just after a rising edge
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      mismatches++;
      tally_and_finish();
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task automatic s_regs();
    apb(1'h0, `RFC_IDX_CONTROL, 8'h00);
    chk("control reset", rdv, 32'h0000_0000);
    chk("mapped ok", {31'h0, errv}, 32'h0000_0000);
    apb(1'h1, `RFC_IDX_CONTROL, 8'h3f);
    apb(1'h0, `RFC_IDX_CONTROL, 8'h00);
    chk("control bit5", rdv, 32'h0000_001f);
    pstrb <= 4'he;
    apb(1'h1, `RFC_IDX_CONTROL, 8'h00);
    pstrb <= 4'hf;
    apb(1'h0, `RFC_IDX_CONTROL, 8'h00);
    chk("strobe off", rdv, 32'h0000_001f);
    apb(1'h0, 8'h01, 8'h00);
    chk("unmapped error", {31'h0, errv}, 32'h0000_0001);
    chk("port out", {13'h0, net_out}, {13'h0, gpio_out});
    chk("port oe", {13'h0, net_oe}, 32'h0000_0000);
    chk("cap port", {30'h0, cap_out, cap_oe}, 32'h0000_0003);
  endtask : s_regs

  task automatic s_pins();
    logic [18:0] m;
    for (int s = 0; s < 20; s++) begin
      m = (s < 19) ? (19'h0_0001 << s) : 19'h0_0000;
      apb(1'h1, `RFC_IDX_CONTROL, {3'h4, s[4:0]});
      apb(1'h0, `RFC_IDX_CONTROL, 8'h00);
      chk("sel readback", rdv, {24'h00_0000, 3'h4, s[4:0]});
      chk("sel oe", {13'h0, net_oe}, {13'h0, m});
      chk("sel out", {13'h0, net_out}, {13'h0, gpio_out & ~m});
      chk("cap oe", {30'h0, cap_out, cap_oe}, 32'h0000_0000);
    end
  endtask : s_pins

  task automatic s_conv(input logic [7:0] mask, input logic taken);
    int n;
    logic [14:0] c;
    int base;
    base = irq_cnt;
    apb(1'h1, `RFC_IDX_IRQ_MASK, mask);
    apb(1'h1, `RFC_IDX_IRQ_CTL, 8'h01);
    apb(1'h1, `RFC_IDX_IRQ_FLAGS, 8'h00);
    apb(1'h1, `RFC_IDX_CONTROL, 8'hc3);
    apb(1'h0, `RFC_IDX_CONTROL, 8'h00);
    chk("started", rdv, 32'h0000_00c3);
    n = 0;
    do begin
      apb(1'h0, `RFC_IDX_IRQ_FLAGS, 8'h00);
      n++;
    end while (rdv[6] !== 1'h1 && n < 40);
    chk("done flag", rdv, 32'h0000_0040);
    apb(1'h0, `RFC_IDX_CONTROL, 8'h00);
    chk("start cleared", rdv, 32'h0000_0083);
    apb(1'h0, `RFC_IDX_RESULT_LOW, 8'h00);
    c[7:0] = rdv[7:0];
    apb(1'h0, `RFC_IDX_RESULT_HIGH, 8'h00);
    c[14:8] = rdv[6:0];
    chk("overflow", {31'h0, rdv[7]}, 32'h0000_0000);
    chk("count", {31'h0, c >= 15'h0002 && c <= 15'h0005}, 32'h1);
    chk("irq taken", irq_cnt - base, {31'h0, taken});
    chk("vector", {20'h0, irq_vec}, 32'h0000_0001);
    apb(1'h0, `RFC_IDX_IRQ_CTL, 8'h00);
    chk("global enable", rdv, {31'h0, !taken});
    apb(1'h1, `RFC_IDX_IRQ_FLAGS, 8'h00);
    apb(1'h0, `RFC_IDX_IRQ_FLAGS, 8'h00);
    chk("flag cleared", rdv, 32'h0000_0000);
  endtask : s_conv

  task automatic s_abort();
    apb(1'h1, `RFC_IDX_CONTROL, 8'hc3);
    apb(1'h1, `RFC_IDX_CONTROL, 8'h83);
    repeat (GATE + 8) @(posedge pclk);
    apb(1'h0, `RFC_IDX_IRQ_FLAGS, 8'h00);
    chk("abort no flag", rdv, 32'h0000_0000);
    apb(1'h0, `RFC_IDX_CONTROL, 8'h00);
    chk("abort start", rdv, 32'h0000_0083);
  endtask : s_abort

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    s_regs();
    s_pins();
    s_conv(8'h40, 1'h1);
    s_conv(8'h00, 1'h0);
    s_abort();
    tally_and_finish();
  end
endmodule : resistor_frequency_converter_ctl_tb

// [rfc_consts.svh]
// Purpose: Constants of the resistor-to-frequency converter control block
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef RFC_CONSTS_SVH
`define RFC_CONSTS_SVH

`define RFC_ADDR_W 10
`define RFC_IDX_CONTROL 8'h0a
`define RFC_IDX_RESULT_LOW 8'h0b
`define RFC_IDX_RESULT_HIGH 8'h0c
`define RFC_IDX_IRQ_MASK 8'h0f
`define RFC_IDX_IRQ_FLAGS 8'h3f
`define RFC_IDX_IRQ_CTL 8'h40

`define RFC_BIT_ENABLE 7
`define RFC_BIT_START 6
`define RFC_SEL_HI 4
`define RFC_SEL_LO 0
`define RFC_BIT_OVERFLOW 7
`define RFC_BIT_DONE_FLAG 6
`define RFC_BIT_DONE_IRQ_EN 6
`define RFC_BIT_GIE_SET 0
`define RFC_BIT_GIE_CLR 1

`define RFC_NUM_CHAN 19
`define RFC_SEL_MAX 5'h12
`define RFC_RESULT_W 15
`define RFC_GATE_W 16
`define RFC_GATE_CYCLES 4096
`define RFC_IRQ_VECTOR 12'h001
`define RFC_SEL_RESET 5'h00
`define RFC_BYTE_ZERO 8'h00
`define RFC_WORD_ZERO 32'h0000_0000
`define RFC_OFFSET_ZERO 2'h0

`endif

// [rfc_counter.sv]
// Purpose: Conversion counter with sticky overflow
// Assumes: Clear has priority over increment
// Notes: Overflow stays set until the next clear
`timescale 1ns/1ps

module rfc_counter #(
  parameter int WIDTH = 15
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic inc,
  output logic [WIDTH-1:0] count,
  output logic overflow
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic overflow;
  } rfc_cnt_st_t;

  rfc_cnt_st_t r;
  rfc_cnt_st_t n;
  logic [WIDTH:0] sum;

  always_comb begin
    n = r;
    sum = {1'b0, r.count} + {{WIDTH{1'b0}}, 1'b1};
    if (clear) begin
      n.count = '0;
      n.overflow = 1'b0;
    end else if (inc) begin
      n.count = sum[WIDTH-1:0];
      if (sum[WIDTH]) begin
        n.overflow = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign count = r.count;
  assign overflow = r.overflow;

endmodule : rfc_counter

// [rfc_ctl.sv]
// Purpose: Resistor-to-frequency converter control with APB registers
// Assumes: Port logic outside supplies ordinary pin drive and enables
// Notes: Zero-wait APB slave; read data captured in the setup cycle
// Operation
// R01 - Five-bit select picks one of 19 networks
// R02 - Enabled: only selected pin acts as converter
// R03 - Disabled: all shared pins stay port pins
// R04 - Enabled: capacitor pin becomes converter connection
// R05 - Setting start begins a conversion
// R06 - Hardware clears start at end; software aborts
// R07 - Control bit 5 always reads zero
// R08 - Fifteen-bit result readable in two registers
// R09 - Overflow set on wrap, cleared by reset
// R10 - Completion sets done flag; software clears it
// R11 - Taken interrupt clears global enable, vectors 001h
// R12 - Interrupt needs its individual enable set
// R13 - Counter and overflow cleared at start
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "rfc_consts.svh"

module rfc_ctl #(
  parameter int GATE_CYCLES = `RFC_GATE_CYCLES,
  parameter int NUM_CHAN = `RFC_NUM_CHAN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RFC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CHAN-1:0] gpio_out,
  input wire logic [NUM_CHAN-1:0] gpio_oe,
  output logic [NUM_CHAN-1:0] network_output_pin_out,
  output logic [NUM_CHAN-1:0] network_output_pin_oe,
  input wire logic gpio_cap_out,
  input wire logic gpio_cap_oe,
  input wire logic capacitor_pin_in,
  output logic capacitor_pin_out,
  output logic capacitor_pin_oe,
  output logic irq_vector_req,
  output logic [11:0] irq_vector
);

  localparam logic [`RFC_GATE_W-1:0] GATE_LAST =
    `RFC_GATE_W'(GATE_CYCLES - 1);

  rfc_pkg::rfc_ctl_st_t r;
  rfc_pkg::rfc_ctl_st_t n;

  logic cap_sync;
  logic cap_rise;
  logic cnt_clear;
  logic cnt_inc;
  logic [`RFC_RESULT_W-1:0] count;
  logic overflow;
  logic [NUM_CHAN-1:0] sel_hot;
  logic [NUM_CHAN-1:0] route;
  logic sel_valid;
  logic net_drive;
  logic access;
  logic wr;
  logic rd_setup;
  logic hit;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic wr_ctl;
  logic wr_flags;
  logic wr_mask;
  logic wr_irq_ctl;
  logic start_req;
  logic abort_req;
  logic hw_done;
  logic [7:0] rd_mux;

  rfc_sync #(
    .WIDTH(1)
  ) u_cap_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(capacitor_pin_in),
    .q(cap_sync)
  );

  rfc_counter #(
    .WIDTH(`RFC_RESULT_W)
  ) u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .clear(cnt_clear),
    .inc(cnt_inc),
    .count(count),
    .overflow(overflow)
  );

  // Channel decode; codes above the last channel route nothing
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      sel_hot[i] = (r.sel == 5'(i)); // see R01
    end
  end

  assign sel_valid = (r.sel <= `RFC_SEL_MAX); // see R01
  assign route = r.enable ? sel_hot : '0; // see R02 see R03

  // Relaxation drive: charge while the capacitor node is low
  assign net_drive = (r.state == rfc_pkg::RFC_RUN) & ~cap_sync;

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      network_output_pin_out[i] = route[i] ? net_drive : gpio_out[i]; // see R02
      network_output_pin_oe[i] = route[i] ? 1'b1 : gpio_oe[i]; // see R03
    end
  end

  // Capacitor pin is sensed only, never driven, while enabled
  assign capacitor_pin_out = r.enable ? 1'b0 : gpio_cap_out; // see R04
  assign capacitor_pin_oe = r.enable ? 1'b0 : gpio_cap_oe; // see R04 see R03

  assign cap_rise = cap_sync & ~r.cap_q;

  // APB decode
  assign idx = paddr[`RFC_ADDR_W-1:2];
  assign hit = (paddr[1:0] == `RFC_OFFSET_ZERO) &&
               ((idx == `RFC_IDX_CONTROL) ||
                (idx == `RFC_IDX_RESULT_LOW) ||
                (idx == `RFC_IDX_RESULT_HIGH) ||
                (idx == `RFC_IDX_IRQ_MASK) ||
                (idx == `RFC_IDX_IRQ_FLAGS) ||
                (idx == `RFC_IDX_IRQ_CTL));
  assign access = psel & penable;
  assign wr = access & pwrite & hit & pstrb[0];
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign wr_ctl = wr && (idx == `RFC_IDX_CONTROL);
  assign wr_flags = wr && (idx == `RFC_IDX_IRQ_FLAGS);
  assign wr_mask = wr && (idx == `RFC_IDX_IRQ_MASK);
  assign wr_irq_ctl = wr && (idx == `RFC_IDX_IRQ_CTL);
  assign start_req = wr_ctl & wbyte[`RFC_BIT_START];
  assign abort_req = wr_ctl & ~wbyte[`RFC_BIT_START];
  assign hw_done = (r.state == rfc_pkg::RFC_RUN) && (r.gate == GATE_LAST) &&
                   ~abort_req;

  always_comb begin
    rd_mux = `RFC_BYTE_ZERO;
    unique case (idx)
      `RFC_IDX_CONTROL: begin
        // Bit 5 is tied low
        rd_mux = {r.enable, r.start, 1'b0, r.sel}; // see R07
      end
      `RFC_IDX_RESULT_LOW: begin
        rd_mux = count[7:0]; // see R08
      end
      `RFC_IDX_RESULT_HIGH: begin
        rd_mux = {overflow, count[14:8]}; // see R08 see R09
      end
      `RFC_IDX_IRQ_MASK: begin
        rd_mux = {1'b0, r.irq_en, 6'h00};
      end
      `RFC_IDX_IRQ_FLAGS: begin
        rd_mux = {1'b0, r.done_flag, 6'h00};
      end
      `RFC_IDX_IRQ_CTL: begin
        rd_mux = {7'h00, r.global_interrupt_enable};
      end
      default: begin
        rd_mux = `RFC_BYTE_ZERO;
      end
    endcase
  end

  always_comb begin
    n = r;
    n.vec_pulse = 1'b0;
    n.cap_q = cap_sync;
    cnt_clear = 1'b0;
    cnt_inc = 1'b0;
    if (wr_ctl) begin
      n.enable = wbyte[`RFC_BIT_ENABLE];
      n.sel = wbyte[`RFC_SEL_HI:`RFC_SEL_LO];
    end
    unique case (r.state)
      rfc_pkg::RFC_IDLE: begin
        if (start_req) begin
          n.state = rfc_pkg::RFC_RUN; // see R05
          n.start = 1'b1;
          n.gate = '0;
          cnt_clear = 1'b1; // see R13
        end
      end
      rfc_pkg::RFC_RUN: begin
        if (abort_req) begin
          n.state = rfc_pkg::RFC_IDLE; // see R06
          n.start = 1'b0;
        end else if (hw_done) begin
          n.state = rfc_pkg::RFC_IDLE;
          n.start = 1'b0; // see R06
        end else begin
          n.gate = r.gate + `RFC_GATE_W'(1);
          cnt_inc = cap_rise; // see R05
        end
      end
    endcase
    if (wr_mask) begin
      n.irq_en = wbyte[`RFC_BIT_DONE_IRQ_EN];
    end
    if (wr_flags) begin
      n.done_flag = wbyte[`RFC_BIT_DONE_FLAG];
    end
    // Completion wins over a clearing write in the same cycle
    if (hw_done) begin
      n.done_flag = 1'b1; // see R10
    end
    if (wr_irq_ctl && wbyte[`RFC_BIT_GIE_CLR]) begin
      n.global_interrupt_enable = 1'b0;
    end else if (wr_irq_ctl && wbyte[`RFC_BIT_GIE_SET]) begin
      n.global_interrupt_enable = 1'b1;
    end
    if (r.done_flag && r.irq_en && r.global_interrupt_enable) begin
      n.global_interrupt_enable = 1'b0; // see R11 see R12
      n.vec_pulse = 1'b1;
    end
    if (rd_setup) begin
      n.rdata = hit ? rd_mux : `RFC_BYTE_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pready = access;
  assign pslverr = access & ~hit;
  assign prdata = {24'h00_0000, r.rdata};
  assign irq_vector_req = r.vec_pulse;
  assign irq_vector = `RFC_IRQ_VECTOR; // see R11

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  localparam int SETTLE_MIN = 1;
  localparam int SETTLE_MAX = 2;

  AST_PORT_WHEN_OFF: assert property ( // see R03
    !r.enable |-> (network_output_pin_oe == gpio_oe) &&
      (network_output_pin_out == gpio_out) &&
      (capacitor_pin_oe == gpio_cap_oe))
    else $error("shared pins not in port mode while disabled");

  AST_CAP_SENSE: assert property ( // see R04
    r.enable |-> !capacitor_pin_oe && !capacitor_pin_out)
    else $error("capacitor pin driven while converter enabled");

  AST_ONLY_SELECTED: assert property ( // see R02
    r.enable |-> ((network_output_pin_oe & ~sel_hot) == (gpio_oe & ~sel_hot))
      && (!sel_valid || network_output_pin_oe[r.sel]))
    else $error("unselected pin taken or selected pin not driven");

  AST_START_CLEARS: assert property ( // see R05 see R13
    (r.state == rfc_pkg::RFC_IDLE) && start_req |=>
      (r.state == rfc_pkg::RFC_RUN) && r.start && (count == '0) && !overflow)
    else $error("start did not begin a cleared conversion");

  AST_DONE_SEQ: assert property ( // see R06 see R10
    hw_done |=> !r.start && r.done_flag &&
      (r.state == rfc_pkg::RFC_IDLE))
    else $error("completion did not clear start and set flag");

  AST_ABORT: assert property ( // see R06
    (r.state == rfc_pkg::RFC_RUN) && abort_req |=>
      (r.state == rfc_pkg::RFC_IDLE) && !r.start && $stable(r.done_flag))
    else $error("abort did not stop conversion quietly");

  AST_BIT5_ZERO: assert property ( // see R07
    rd_setup && (idx == `RFC_IDX_CONTROL) |=> !prdata[5])
    else $error("control bit 5 read as one");

  AST_HIGH_READ: assert property ( // see R08 see R09
    rd_setup && (idx == `RFC_IDX_RESULT_HIGH) |=>
      prdata[7:0] == {$past(overflow), $past(count[14:8])})
    else $error("high result read wrong");

  AST_OV_STICKY: assert property ( // see R09
    overflow && !cnt_clear |=> overflow)
    else $error("overflow dropped without counter reset");

  AST_VECTOR: assert property ( // see R11 see R12
    r.done_flag && r.irq_en && r.global_interrupt_enable |-> ##[SETTLE_MIN:SETTLE_MAX]
      (!r.global_interrupt_enable && irq_vector_req && irq_vector == `RFC_IRQ_VECTOR))
    else $error("pending interrupt not taken");

  AST_MASKED: assert property ( // see R12
    !r.irq_en |=> !irq_vector_req)
    else $error("interrupt taken while masked");

  AST_FLAG_HOLD: assert property ( // see R10
    r.done_flag && !wr_flags |=> r.done_flag)
    else $error("done flag cleared without software");

  AST_DONE_ONLY: assert property ( // see R10
    !r.done_flag && !wr_flags && !hw_done |=> !r.done_flag)
    else $error("done flag set without completion");

  AST_OV_SET: assert property ( // see R09
    cnt_inc && (count == '1) |=> overflow)
    else $error("overflow not set on counter wrap");

  AST_CAP_PORT: assert property ( // see R03
    !r.enable |-> (capacitor_pin_out == gpio_cap_out))
    else $error("capacitor pin drive not from port while disabled");

  AST_NO_CHANNEL: assert property ( // see R01
    r.enable && !sel_valid |-> (network_output_pin_oe == gpio_oe) &&
      (network_output_pin_out == gpio_out))
    else $error("undocumented select code took a pin");

  AST_SEL_IDLE_LOW: assert property ( // see R02
    r.enable && sel_valid && (r.state == rfc_pkg::RFC_IDLE) |->
      !network_output_pin_out[r.sel])
    else $error("selected pin driven high while idle");

  AST_VEC_PULSE: assert property ( // see R11
    irq_vector_req |=> !irq_vector_req)
    else $error("interrupt request longer than one cycle");

  AST_IDLE_HOLD: assert property ( // see R06
    (r.state == rfc_pkg::RFC_IDLE) && !cnt_clear |=> $stable(count))
    else $error("counter moved while no conversion runs");

  AST_RUN_START: assert property ( // see R05
    (r.state == rfc_pkg::RFC_RUN) |-> r.start)
    else $error("conversion running with start bit low");

  AST_IDLE_START: assert property ( // see R06
    (r.state == rfc_pkg::RFC_IDLE) |-> !r.start)
    else $error("start bit high with no conversion running");

endmodule : rfc_ctl

// [rfc_net_model.sv]
// Purpose: External resistor/capacitor network seen on the capacitor pin
// Assumes: Network oscillates only while a network pin is driven
// Notes: Half period in ns is a parameter
`timescale 1ns/1ps

module rfc_net_model #(
  parameter int HALF_NS = 110
) (
  input wire logic [18:0] net_oe,
  input wire logic cap_oe,
  output logic cap_in
);
  initial begin
    cap_in = 1'h0;
    forever begin
      #(HALF_NS);
      // Capacitor only swings while the block senses it
      if (|net_oe && !cap_oe) begin
        cap_in = ~cap_in;
      end
    end
  end
endmodule : rfc_net_model

// [rfc_pkg.sv]
// Purpose: Types shared by the converter control block
// Assumes: Constants header supplies the widths
// Notes: Nothing here is imported; users write rfc_pkg::name
`include "rfc_consts.svh"

package rfc_pkg;

  typedef enum logic [1:0] {
    RFC_IDLE = 2'h0,
    RFC_RUN = 2'h1
  } rfc_state_t;

  typedef struct packed {
    rfc_state_t state;
    logic enable;
    logic start;
    logic [4:0] sel;
    logic done_flag;
    logic irq_en;
    logic global_interrupt_enable;
    logic [`RFC_GATE_W-1:0] gate;
    logic [7:0] rdata;
    logic vec_pulse;
    logic cap_q;
  } rfc_ctl_st_t;

endpackage : rfc_pkg

// [rfc_sync.sv]
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Input is asynchronous to pclk
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps

module rfc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } rfc_sync_st_t;

  rfc_sync_st_t r;
  rfc_sync_st_t n;

  always_comb begin
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.s2;

endmodule : rfc_sync
